// ---- shared/power_saving_defs.vh ----
// register map, field positions, reset values and bus codes of the power-saving control block
// assumes a single AHB-Lite slave with word-aligned 32-bit registers
`ifndef POWER_SAVING_DEFS_VH
`define POWER_SAVING_DEFS_VH

// register indexes, byte address is four times the index
`define PWR_CTRL_IDX      10'h087
`define SAVE_STATUS_IDX   10'h088
`define SERIAL_CFG_IDX    10'h089

// reset values
`define PWR_CTRL_RESET    8'h00
`define SERIAL_CFG_RESET  2'h0

// power_control fields
`define BAUD_DOUBLE_BIT   7
`define PD_START_BIT      6
`define IDLE_START_BIT    5
`define USER_FLAG_1_BIT   3
`define USER_FLAG_0_BIT   2
`define PD_ENABLE_BIT     1
`define IDLE_ENABLE_BIT   0

// save_status fields
`define STAT_IDLE_BIT     0
`define STAT_PDOWN_BIT    1
`define STAT_GATE_BIT     2
`define STAT_PD_ARM_BIT   3
`define STAT_IDLE_ARM_BIT 4

// serial_config fields
`define SER_MODE_LSB      0
`define SER_MODE_MSB      1
`define SER_MODE_FIXED    2'h0

// bus codes
`define HTRANS_NONSEQ     2'h2
`define HTRANS_SEQ        2'h3
`define HRESP_OKAY        1'b0

`endif

// ---- logic/baud_rate_gen.v ----
// baud-rate enable generator for the serial channel
// assumes one clock; run drops while the clocks are stopped
`timescale 1ns/1ps
`include "power_saving_defs.vh"

module baud_rate_gen #(
  parameter CNT_W    = 16,
  parameter BAUD_DIV = 16'h0340
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             run,
  input  wire             double_rate,
  input  wire [1:0]       serial_mode,
  output reg              tick_q
);

  reg  [CNT_W-1:0] cnt_q;
  reg  [CNT_W-1:0] limit;
  wire [CNT_W-1:0] full_div;

  assign full_div = BAUD_DIV[CNT_W-1:0];

  // half the period when doubling applies
  always @* begin
    if (double_rate && (serial_mode != `SER_MODE_FIXED)) begin
      limit = (full_div >> 1) - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      limit = full_div - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= {CNT_W{1'b0}};
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q  <= {CNT_W{1'b0}};
      tick_q <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q  <= {CNT_W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

endmodule // baud_rate_gen

// ---- logic/saving_mode_seq.v ----
// run / idle / power-down mode sequencer
// assumes start pulses come only while running
`timescale 1ns/1ps

module saving_mode_seq (
  input  wire clk,
  input  wire rst_n,
  input  wire idle_go,
  input  wire pdown_go,
  input  wire wake_event,
  output reg  idle_mode_q,
  output reg  pdown_mode_q,
  output reg  idle_exit_q
);

  localparam [1:0] ST_RUN   = 2'b00;
  localparam [1:0] ST_IDLE  = 2'b01;
  localparam [1:0] ST_PDOWN = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg       exit_d;

  always @* begin
    state_d = state_q;
    exit_d  = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (pdown_go) begin
          state_d = ST_PDOWN;
        end else if (idle_go) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wake_event) begin
          state_d = ST_RUN;
          exit_d  = 1'b1;
        end
      end
      ST_PDOWN: begin
        state_d = ST_PDOWN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_RUN;
      idle_mode_q  <= 1'b0;
      pdown_mode_q <= 1'b0;
      idle_exit_q  <= 1'b0;
    end else begin
      state_q      <= state_d;
      idle_mode_q  <= (state_d == ST_IDLE);
      pdown_mode_q <= (state_d == ST_PDOWN);
      idle_exit_q  <= exit_d;
    end
  end

endmodule // saving_mode_seq

// ---- logic/power_saving_control.v ----
// power control register block with AHB-Lite slave, mode sequencing and baud enable
// assumes one AHB-Lite master, word transfers only, pins synchronous to hclk
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "power_saving_defs.vh"

// Behaviour
// - baud-doubling bit set doubles serial baud rate in modes one to three
// - writing power-down start enters power-down right after that write completes
// - writing idle start enters idle right after that write completes, unless the same write starts power-down
// - power-down start honoured only while power-down enable is set
// - idle start honoured only while idle enable is set
// - enable and start bits ignored unless the saving gate pin permits
// - two free user flags at bits three and two, no hardware effect
// - entry needs separate enable then start writes, never one write
// - reduced variant keeps only the baud-doubling bit
module power_saving_control #(
  parameter HAS_SAVING = 1,
  parameter BAUD_CNT_W = 16,
  parameter BAUD_DIV   = 16'h0340
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        saving_gate_pin,
  input  wire        wake_event,
  output reg         baud_double,
  output wire        baud_tick,
  output wire        idle_mode,
  output wire        powerdown_mode,
  output reg         cpu_clk_en,
  output reg         periph_clk_en
);

  // register index taken from a byte address
  function [9:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[11:2];
    end
  endfunction

  // address outside the register window
  function addr_high;
    input [31:0] addr;
    begin
      addr_high = |addr[31:12];
    end
  endfunction

  // write data phase aimed at one register
  function wr_aimed;
    input       pend;
    input       out;
    input [9:0] idx;
    input [9:0] target;
    begin
      wr_aimed = pend & ~out & (idx == target);
    end
  endfunction

  // bus front end
  wire       bus_accept;
  reg        wr_pend_q;
  reg  [9:0] wr_idx_q;
  reg        wr_out_q;
  wire       wr_pc;
  wire       wr_ser;
  wire       rd_accept;
  wire [9:0] rd_idx;
  wire       rd_out;
  reg  [31:0] rd_word;

  // reset image of power_control
  localparam [7:0] PC_RESET = `PWR_CTRL_RESET;

  // power_control fields
  reg        baud_q;
  reg        baud_d;
  reg        pdstart_q;
  reg        pdstart_d;
  reg        ids_q;
  reg        ids_d;
  reg        uflag1_q;
  reg        uflag1_d;
  reg        uflag0_q;
  reg        uflag0_d;
  reg        pden_q;
  reg        pden_d;
  reg        ide_q;
  reg        ide_d;
  reg  [7:0] pc_view;

  // serial configuration
  reg  [1:0] ser_mode_q;
  reg  [1:0] ser_mode_d;

  // mode control
  reg        idle_go;
  reg        pdown_go;
  wire       running;
  wire       idle_exit;
  wire [7:0] status_view;

  assign bus_accept = hsel & hready & ((htrans == `HTRANS_NONSEQ) | (htrans == `HTRANS_SEQ));
  assign rd_accept  = bus_accept & ~hwrite;
  assign rd_idx     = reg_index(haddr);
  assign rd_out     = addr_high(haddr);
  assign wr_pc      = wr_aimed(wr_pend_q, wr_out_q, wr_idx_q, `PWR_CTRL_IDX);
  assign wr_ser     = wr_aimed(wr_pend_q, wr_out_q, wr_idx_q, `SERIAL_CFG_IDX);
  assign running    = ~idle_mode & ~powerdown_mode;

  // write address phase capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 10'h000;
      wr_out_q  <= 1'b0;
    end else if (hready) begin
      wr_pend_q <= bus_accept & hwrite;
      wr_idx_q  <= reg_index(haddr);
      wr_out_q  <= addr_high(haddr);
    end
  end

  // next values of the power_control fields
  always @* begin
    baud_d    = baud_q;
    pdstart_d = pdstart_q;
    ids_d     = ids_q;
    uflag1_d  = uflag1_q;
    uflag0_d  = uflag0_q;
    pden_d    = pden_q;
    ide_d     = ide_q;
    idle_go   = 1'b0;
    pdown_go  = 1'b0;
    if (wr_pc) begin
      baud_d = hwdata[`BAUD_DOUBLE_BIT];
      if (HAS_SAVING != 0) begin
        uflag1_d = hwdata[`USER_FLAG_1_BIT];
        uflag0_d = hwdata[`USER_FLAG_0_BIT];
        if (saving_gate_pin) begin
          pden_d = hwdata[`PD_ENABLE_BIT];
          ide_d  = hwdata[`IDLE_ENABLE_BIT];
          if (hwdata[`PD_START_BIT] && pden_q && running) begin
            pdown_go  = 1'b1;
            pdstart_d = 1'b1;
            pden_d    = 1'b0;
          end else if (hwdata[`IDLE_START_BIT] && ide_q && running) begin
            idle_go = 1'b1;
            ids_d   = 1'b1;
            ide_d   = 1'b0;
          end
        end
      end
    end
    if (!saving_gate_pin) begin
      pden_d = 1'b0;
      ide_d  = 1'b0;
    end
    // idle start cleared on exit
    // a fresh start in the exit cycle wins
    if (idle_exit && !idle_go) begin
      ids_d = 1'b0;
    end
    if (HAS_SAVING == 0) begin
      pdstart_d = 1'b0;
      ids_d     = 1'b0;
      uflag1_d  = 1'b0;
      uflag0_d  = 1'b0;
      pden_d    = 1'b0;
      ide_d     = 1'b0;
    end
  end

  always @* begin
    ser_mode_d = ser_mode_q;
    if (wr_ser) begin
      ser_mode_d = hwdata[`SER_MODE_MSB:`SER_MODE_LSB];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_q     <= PC_RESET[`BAUD_DOUBLE_BIT];
      pdstart_q  <= PC_RESET[`PD_START_BIT];
      ids_q      <= PC_RESET[`IDLE_START_BIT];
      uflag1_q   <= PC_RESET[`USER_FLAG_1_BIT];
      uflag0_q   <= PC_RESET[`USER_FLAG_0_BIT];
      pden_q     <= PC_RESET[`PD_ENABLE_BIT];
      ide_q      <= PC_RESET[`IDLE_ENABLE_BIT];
      ser_mode_q <= `SERIAL_CFG_RESET;
    end else begin
      baud_q     <= baud_d;
      pdstart_q  <= pdstart_d;
      ids_q      <= ids_d;
      uflag1_q   <= uflag1_d;
      uflag0_q   <= uflag0_d;
      pden_q     <= pden_d;
      ide_q      <= ide_d;
      ser_mode_q <= ser_mode_d;
    end
  end

  // read views built from next values so a read after a write sees it
  always @* begin
    pc_view                   = 8'h00;
    pc_view[`BAUD_DOUBLE_BIT] = baud_d;
    pc_view[`PD_START_BIT]    = pdstart_d;
    pc_view[`IDLE_START_BIT]  = ids_d;
    pc_view[`USER_FLAG_1_BIT] = uflag1_d;
    pc_view[`USER_FLAG_0_BIT] = uflag0_d;
    pc_view[`PD_ENABLE_BIT]   = pden_d;
    pc_view[`IDLE_ENABLE_BIT] = ide_d;
  end

  assign status_view = {3'h0, ide_q, pden_q, saving_gate_pin, powerdown_mode, idle_mode};

  always @* begin
    rd_word = 32'h00000000;
    if (!rd_out) begin
      case (rd_idx)
        `PWR_CTRL_IDX: begin
          rd_word = {24'h000000, pc_view};
        end
        `SAVE_STATUS_IDX: begin
          rd_word = {24'h000000, status_view};
        end
        `SERIAL_CFG_IDX: begin
          rd_word = {30'h00000000, ser_mode_d};
        end
        default: begin
          rd_word = 32'h00000000;
        end
      endcase
    end
  end

  // zero-wait-state answers, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
      hrdata    <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
      if (rd_accept) begin
        hrdata <= rd_word;
      end
    end
  end

  saving_mode_seq u_seq (
    .clk          (hclk),
    .rst_n        (hresetn),
    .idle_go      (idle_go),
    .pdown_go     (pdown_go),
    .wake_event   (wake_event),
    .idle_mode_q  (idle_mode),
    .pdown_mode_q (powerdown_mode),
    .idle_exit_q  (idle_exit)
  );

  // clock enables follow the mode one cycle later
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= 1'b1;
      baud_double   <= 1'b0;
    end else begin
      cpu_clk_en    <= running;
      periph_clk_en <= ~powerdown_mode;
      baud_double   <= baud_q;
    end
  end

  baud_rate_gen #(
    .CNT_W    (BAUD_CNT_W),
    .BAUD_DIV (BAUD_DIV)
  ) u_baud (
    .clk         (hclk),
    .rst_n       (hresetn),
    .run         (~powerdown_mode),
    .double_rate (baud_q),
    .serial_mode (ser_mode_q),
    .tick_q      (baud_tick)
  );

endmodule // power_saving_control

// ---- testbench/power_saving_checker_assertions.sv ----
// port checker for the power-saving control block
// assumes it is bound to every instance of the block
`timescale 1ns/1ps

module power_saving_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        saving_gate_pin,
  input wire logic        wake_event,
  input wire logic        baud_tick,
  input wire logic        idle_mode,
  input wire logic        powerdown_mode,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en
);
  logic wr_hit;
  // address phase of a write to power_control
  assign wr_hit = hsel && htrans[1] && hwrite && (haddr == 32'h0000021C);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wake; idle_mode && wake_event; endsequence
  sequence s_exit; !idle_mode ##1 cpu_clk_en; endsequence
  property p_entry; $rose(idle_mode || powerdown_mode) |-> $past(saving_gate_pin) && $past(wr_hit, 2); endproperty
  property p_wake; s_wake |=> s_exit; endproperty
  property p_idle_hold; idle_mode && !wake_event |=> idle_mode; endproperty
  property p_pd_hold; powerdown_mode |=> powerdown_mode; endproperty
  property p_idle_clk; idle_mode |=> !cpu_clk_en; endproperty
  property p_pd_clk; powerdown_mode |=> !cpu_clk_en && !periph_clk_en; endproperty
  property p_run_clk; !idle_mode && !powerdown_mode |=> cpu_clk_en && periph_clk_en; endproperty
  property p_excl; !(idle_mode && powerdown_mode); endproperty
  property p_pd_tick; powerdown_mode [*3] |-> !baud_tick; endproperty
  property p_bus; hreadyout && !hresp; endproperty
  a_entry: assert property (p_entry) else $error("mode entered without gated write");
  a_wake: assert property (p_wake) else $error("idle did not end on wake");
  a_idle_hold: assert property (p_idle_hold) else $error("idle left without wake");
  a_pd_hold: assert property (p_pd_hold) else $error("power-down left without reset");
  a_idle_clk: assert property (p_idle_clk) else $error("cpu clock runs in idle");
  a_pd_clk: assert property (p_pd_clk) else $error("clocks run in power-down");
  a_run_clk: assert property (p_run_clk) else $error("clock stopped while running");
  a_excl: assert property (p_excl) else $error("idle and power-down together");
  a_pd_tick: assert property (p_pd_tick) else $error("baud tick in power-down");
  a_bus: assert property (p_bus) else $error("bus not ready or not okay");
endmodule // power_saving_checker

// ---- testbench/power_saving_control_tb.sv ----
// self-checking bench for the power-saving control block
// assumes zero-wait AHB-Lite slave; reduced variant shares the bus
`timescale 1ns/1ps

module power_saving_control_tb;
  localparam logic [31:0] PC_A = 32'h0000021C;
  localparam logic [31:0] SC_A = 32'h00000224;
  localparam logic [31:0] ST_A = 32'h00000220;
  logic        hclk, hresetn, hsel, hwrite, saving_gate_pin, wake_event;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, got, got2, d;
  wire         hreadyout, hresp, baud_double, baud_tick, idle_mode, powerdown_mode, cpu_clk_en, periph_clk_en;
  wire  [31:0] hrdata, hrdata2;
  int          fails, num_checks, n;

  power_saving_control #(.BAUD_DIV(16'h0008)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .saving_gate_pin(saving_gate_pin), .wake_event(wake_event), .baud_double(baud_double), .baud_tick(baud_tick),
    .idle_mode(idle_mode), .powerdown_mode(powerdown_mode), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en));

  // reduced variant without saving modes
  power_saving_control #(.HAS_SAVING(0), .BAUD_DIV(16'h0008)) lite (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(hrdata2),
    .saving_gate_pin(saving_gate_pin), .wake_event(wake_event), .baud_double(), .baud_tick(),
    .idle_mode(), .powerdown_mode(), .cpu_clk_en(), .periph_clk_en());

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    got = hrdata;
    got2 = hrdata2;
  endtask

  // skips two ticks, then counts cycles to the next
  task automatic period(input int e);
    repeat (2) begin
      n = 0;
      do begin @(negedge hclk); n++; end while (baud_tick !== 1'b1 && n < 64);
    end
    n = 0;
    do begin @(negedge hclk); n++; end while (baud_tick !== 1'b1 && n < 64);
    chk(n, e);
    @(posedge hclk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    #200000;
    fails++;
    stop_test;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hwdata = 32'h0;
    saving_gate_pin = 1'b1;
    wake_event = 1'b0;
    fails = 0;
    num_checks = 0;
    n = $urandom(11);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(PC_A, 0, 0);
    chk(got, 32'h0);
    repeat (6) begin
      d = $urandom & 32'h9C;
      xfer(PC_A, 1, d);
      xfer(PC_A, 0, 0);
      chk(got, d & 32'h8C);
      chk(got2, d & 32'h80);
      chk(baud_double, d[7]);
      chk(idle_mode, 0);
    end
    xfer(32'h0000121C, 1, 32'hFF);
    xfer(32'h0000121C, 0, 0);
    chk(got, 32'h0);
    xfer(PC_A, 0, 0);
    chk(got, d & 32'h8C);
    xfer(PC_A, 1, 32'h21);
    xfer(PC_A, 0, 0);
    chk(got, 32'h01);
    chk(idle_mode, 0);
    xfer(PC_A, 1, 32'h21);
    @(negedge hclk);
    chk(idle_mode, 1);
    @(negedge hclk);
    chk(cpu_clk_en, 0);
    @(posedge hclk);
    xfer(PC_A, 0, 0);
    chk(got, 32'h20);
    xfer(ST_A, 0, 0);
    chk(got, 32'h05);
    xfer(PC_A, 1, 32'h01);
    wake_event <= 1'b1;
    xfer(PC_A, 1, 32'h21);
    wake_event <= 1'b0;
    @(negedge hclk);
    chk(idle_mode, 1);
    @(posedge hclk);
    xfer(PC_A, 0, 0);
    chk(got, 32'h20);
    wake_event <= 1'b1;
    @(posedge hclk);
    wake_event <= 1'b0;
    @(negedge hclk);
    chk(idle_mode, 0);
    repeat (2) @(posedge hclk);
    xfer(PC_A, 0, 0);
    chk(got, 32'h0);
    xfer(PC_A, 1, 32'h20);
    xfer(PC_A, 0, 0);
    chk(got, 32'h0);
    chk(idle_mode, 0);
    saving_gate_pin <= 1'b0;
    xfer(PC_A, 1, 32'h01);
    xfer(PC_A, 1, 32'h21);
    xfer(PC_A, 0, 0);
    chk(got, 32'h0);
    chk(idle_mode, 0);
    saving_gate_pin <= 1'b1;
    xfer(SC_A, 1, ($urandom % 3) + 1);
    xfer(PC_A, 1, 32'h0);
    period(8);
    xfer(PC_A, 1, 32'h80);
    period(4);
    xfer(SC_A, 1, 32'h0);
    period(8);
    xfer(PC_A, 1, 32'h40);
    @(negedge hclk);
    chk(powerdown_mode, 0);
    @(posedge hclk);
    xfer(PC_A, 1, 32'h02);
    xfer(PC_A, 1, 32'h42);
    @(negedge hclk);
    chk(powerdown_mode, 1);
    @(posedge hclk);
    wake_event <= 1'b1;
    @(posedge hclk);
    wake_event <= 1'b0;
    repeat (2) @(negedge hclk);
    chk(powerdown_mode, 1);
    chk(periph_clk_en, 0);
    @(posedge hclk);
    xfer(ST_A, 0, 0);
    chk(got, 32'h06);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    chk(powerdown_mode, 0);
    chk(cpu_clk_en, 1);
    @(posedge hclk);
    xfer(PC_A, 0, 0);
    chk(got, 32'h0);
    stop_test;
  end
endmodule // power_saving_control_tb

bind power_saving_control power_saving_checker checks (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hreadyout(hreadyout), .hresp(hresp), .saving_gate_pin(saving_gate_pin), .wake_event(wake_event),
  .baud_tick(baud_tick), .idle_mode(idle_mode), .powerdown_mode(powerdown_mode),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en));
